// *** design/aer_pkg.sv ***
// Package for the error mask, severity and correctable status bank.
// Assumes a single 125 MHz aclk domain and an AXI4-Lite register master.
// Contract
// - Mask bit 0 blocks training error reports
// - Mask bit 4 blocks link protocol reports
// - Mask bit 12 blocks poisoned TLP reports
// - Mask bit 13 blocks flow control reports
// - Mask bits 14,15 block timeout, abort reports
// - Mask bits 16,17 block unexpected, overflow reports
// - Mask bits 18,19 block malformed, ECRC reports
// - Mask bit 20 blocks unsupported request reports
// - Severity 1 fatal; malformed resets fatal
// - Unexpected completion severity resets non-fatal, writable
// - Receiver error status sticky, write-one clears
// - Bad TLP status sticky, write-one clears
// - Bad DLLP status sticky, write-one clears
// - Replay rollover status sticky, write-one clears
// - Replay timeout status sticky, write-one clears
// - Advisory non-fatal status sticky, write-one clears
package aer_pkg;
  localparam logic [11:0] AER_UNC_MASK_OFFSET = 12'h108;
  localparam logic [11:0] AER_UNC_SEV_OFFSET = 12'h10C;
  localparam logic [11:0] AER_COR_STATUS_OFFSET = 12'h110;
  localparam logic [11:0] AER_IRQ_STATUS_OFFSET = 12'h200;
  localparam logic [11:0] AER_IRQ_MASK_OFFSET = 12'h204;
  localparam logic [31:0] AER_UNC_IMPL = 32'h003FF011;
  localparam logic [31:0] AER_COR_IMPL = 32'h000031C1;
  localparam logic [31:0] AER_UNC_MASK_RESET = 32'h00000000;
  localparam logic [31:0] AER_UNC_SEV_RESET = 32'h00062011;
  localparam logic [31:0] AER_COR_STATUS_RESET = 32'h00000000;
  localparam logic [2:0] AER_IRQ_IMPL = 3'h7;
  localparam logic [2:0] AER_IRQ_MASK_RESET = 3'h0;
  localparam int AER_IRQ_FATAL_BIT = 0;
  localparam int AER_IRQ_NONFATAL_BIT = 1;
  localparam int AER_IRQ_COR_BIT = 2;
  localparam logic [1:0] AER_RESP_OKAY = 2'h0;
  localparam logic [1:0] AER_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    AER_IDLE = 3'h1,
    AER_WRITE_RESP = 3'h2,
    AER_READ_RESP = 3'h4
  } aer_bus_state_type;
endpackage

// *** design/aer_event_sync.sv ***
// Three-stage synchroniser with edge detect for asynchronous event lines.
// Assumes events are levels that stay high at least two aclk cycles.
`timescale 1ns/10ps
module aer_event_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise_pulse
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] next_stable;
  logic [WIDTH-1:0] next_rise_pulse;

  // Change counts only once stage two and three agree
  always_comb begin
    next_stable = stable;
    next_rise_pulse = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_stable[i] = stage3[i];
        next_rise_pulse[i] = stage3[i] & ~stable[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      stable <= '0;
      rise_pulse <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= next_stable;
      rise_pulse <= next_rise_pulse;
    end
  end
endmodule // aer_event_sync

// *** design/aer_bank.sv ***
// Error mask, severity and correctable status bank with AXI4-Lite slave.
// Assumes error events arrive as asynchronous levels from the link core.
`timescale 1ns/10ps
module aer_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sticky_resetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] unc_event,
  input wire logic [31:0] cor_event,
  output logic [31:0] unc_report,
  output logic report_fatal,
  output logic report_nonfatal,
  output logic [31:0] cor_detected,
  output logic irq
);
  logic [31:0] unc_mask;
  logic [31:0] unc_sev;
  logic [31:0] cor_status;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [31:0] next_unc_mask;
  logic [31:0] next_unc_sev;
  logic [31:0] next_cor_status;
  logic [2:0] next_irq_status;
  logic [2:0] next_irq_mask;
  aer_pkg::aer_bus_state_type state;
  aer_pkg::aer_bus_state_type next_state;
  logic [11:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic [11:0] next_aw_addr;
  logic next_aw_held;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_w_held;
  logic [1:0] next_bresp;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] unc_pulse;
  logic [31:0] cor_pulse;
  logic [31:0] next_unc_report;
  logic next_report_fatal;
  logic next_report_nonfatal;
  logic [31:0] next_cor_detected;
  logic next_irq;
  logic do_write;
  logic [31:0] byte_mask;
  logic [31:0] wr_bits;

  aer_event_sync #(
    .WIDTH(64)
  ) u_event_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({cor_event, unc_event}),
    .rise_pulse({cor_pulse, unc_pulse})
  );

  // Byte enables widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{w_strb[i]}};
    end
  end

  assign do_write = (state == aer_pkg::AER_IDLE) && aw_held && w_held;
  assign wr_bits = w_data & byte_mask;

  // Bus channel handshakes; address and data may arrive in either order
  always_comb begin
    next_state = state;
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_w_held = w_held;
    next_bresp = s_axi_bresp;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    case (state)
      aer_pkg::AER_IDLE: begin
        if (do_write) begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_state = aer_pkg::AER_WRITE_RESP;
          next_bresp = aer_pkg::AER_RESP_OKAY;
          if (aw_addr[1:0] != 2'h0) begin
            next_bresp = aer_pkg::AER_RESP_SLVERR;
          end else if (aw_addr != aer_pkg::AER_UNC_MASK_OFFSET
              && aw_addr != aer_pkg::AER_UNC_SEV_OFFSET
              && aw_addr != aer_pkg::AER_COR_STATUS_OFFSET
              && aw_addr != aer_pkg::AER_IRQ_STATUS_OFFSET
              && aw_addr != aer_pkg::AER_IRQ_MASK_OFFSET) begin
            next_bresp = aer_pkg::AER_RESP_SLVERR;
          end
        end else if (s_axi_arvalid && s_axi_arready) begin
          next_state = aer_pkg::AER_READ_RESP;
          next_rresp = aer_pkg::AER_RESP_OKAY;
          case (s_axi_araddr)
            aer_pkg::AER_UNC_MASK_OFFSET: next_rdata = unc_mask;
            aer_pkg::AER_UNC_SEV_OFFSET: next_rdata = unc_sev;
            aer_pkg::AER_COR_STATUS_OFFSET: next_rdata = cor_status;
            aer_pkg::AER_IRQ_STATUS_OFFSET: next_rdata = {29'h0, irq_status};
            aer_pkg::AER_IRQ_MASK_OFFSET: next_rdata = {29'h0, irq_mask};
            default: begin
              next_rdata = 32'h0;
              next_rresp = aer_pkg::AER_RESP_SLVERR;
            end
          endcase
        end
      end
      aer_pkg::AER_WRITE_RESP: begin
        if (s_axi_bready) begin
          next_state = aer_pkg::AER_IDLE;
        end
      end
      aer_pkg::AER_READ_RESP: begin
        if (s_axi_rready) begin
          next_state = aer_pkg::AER_IDLE;
        end
      end
      default: next_state = aer_pkg::AER_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= aer_pkg::AER_IDLE;
      aw_addr <= 12'h000;
      aw_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
    end else begin
      state <= next_state;
      aw_addr <= next_aw_addr;
      aw_held <= next_aw_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      w_held <= next_w_held;
      s_axi_awready <= (next_state == aer_pkg::AER_IDLE) && !next_aw_held
          && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= (next_state == aer_pkg::AER_IDLE) && !next_w_held
          && !(s_axi_wvalid && s_axi_wready);
      // Low while a write is about to run, so an accepted read is never dropped
      s_axi_arready <= (next_state == aer_pkg::AER_IDLE) && !(next_aw_held && next_w_held);
      s_axi_bvalid <= (next_state == aer_pkg::AER_WRITE_RESP);
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= (next_state == aer_pkg::AER_READ_RESP);
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // Register updates; hardware set beats software clear
  always_comb begin
    next_unc_mask = unc_mask;
    next_unc_sev = unc_sev;
    next_irq_mask = irq_mask;
    next_cor_status = cor_status;
    next_irq_status = irq_status;
    if (do_write && aw_addr == aer_pkg::AER_UNC_MASK_OFFSET) begin
      // Reserved bits stay zero regardless of write data
      next_unc_mask = ((unc_mask & ~byte_mask) | wr_bits) & aer_pkg::AER_UNC_IMPL;
    end
    if (do_write && aw_addr == aer_pkg::AER_UNC_SEV_OFFSET) begin
      next_unc_sev = ((unc_sev & ~byte_mask) | wr_bits) & aer_pkg::AER_UNC_IMPL;
    end
    if (do_write && aw_addr == aer_pkg::AER_IRQ_MASK_OFFSET) begin
      next_irq_mask = wr_bits[2:0] & aer_pkg::AER_IRQ_IMPL;
    end
    if (do_write && aw_addr == aer_pkg::AER_COR_STATUS_OFFSET) begin
      next_cor_status = cor_status & ~wr_bits;
    end
    next_cor_status = (next_cor_status | cor_pulse) & aer_pkg::AER_COR_IMPL;
    if (do_write && aw_addr == aer_pkg::AER_IRQ_STATUS_OFFSET) begin
      next_irq_status = irq_status & ~wr_bits[2:0];
    end
    next_irq_status[aer_pkg::AER_IRQ_FATAL_BIT] = next_irq_status[aer_pkg::AER_IRQ_FATAL_BIT]
        | next_report_fatal;
    next_irq_status[aer_pkg::AER_IRQ_NONFATAL_BIT] =
        next_irq_status[aer_pkg::AER_IRQ_NONFATAL_BIT] | next_report_nonfatal;
    next_irq_status[aer_pkg::AER_IRQ_COR_BIT] = next_irq_status[aer_pkg::AER_IRQ_COR_BIT]
        | (|next_cor_detected);
  end

  // Masked events never reach the log or message path
  always_comb begin
    next_unc_report = unc_pulse & ~unc_mask & aer_pkg::AER_UNC_IMPL;
    next_report_fatal = |(next_unc_report & unc_sev);
    next_report_nonfatal = |(next_unc_report & ~unc_sev);
    next_cor_detected = cor_pulse & aer_pkg::AER_COR_IMPL;
    next_irq = |(irq_status & irq_mask);
  end

  // Sticky state answers only to the sticky reset, not to aresetn
  always_ff @(posedge aclk) begin
    if (!sticky_resetn) begin
      unc_mask <= aer_pkg::AER_UNC_MASK_RESET;
      unc_sev <= aer_pkg::AER_UNC_SEV_RESET;
      cor_status <= aer_pkg::AER_COR_STATUS_RESET;
    end else begin
      unc_mask <= next_unc_mask;
      unc_sev <= next_unc_sev;
      cor_status <= next_cor_status;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 3'h0;
      irq_mask <= aer_pkg::AER_IRQ_MASK_RESET;
      unc_report <= 32'h00000000;
      report_fatal <= 1'b0;
      report_nonfatal <= 1'b0;
      cor_detected <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      unc_report <= next_unc_report;
      report_fatal <= next_report_fatal;
      report_nonfatal <= next_report_nonfatal;
      cor_detected <= next_cor_detected;
      irq <= next_irq;
    end
  end
endmodule // aer_bank

// *** verif/aer_bank_monitor.sv ***
// Checker of the error bank ports.
// Assumes one aclk domain and events fired one at a time.
`timescale 1ns/10ps
module aer_bank_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] cor_event,
  input wire logic [31:0] unc_report,
  input wire logic report_fatal,
  input wire logic report_nonfatal,
  input wire logic [31:0] cor_detected
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rx_rise;
    $rose(cor_event[0]);
  endsequence
  sequence s_tlp_rise;
    $rose(cor_event[6]);
  endsequence
  AST_RX_SEEN: assert property (s_rx_rise |-> ##[2:6] cor_detected[0])
    else $error("receiver error not flagged");
  AST_TLP_SEEN: assert property (s_tlp_rise |-> ##[2:6] cor_detected[6])
    else $error("bad packet not flagged");
  AST_COR_RSVD: assert property ((cor_detected & ~aer_pkg::AER_COR_IMPL) == 32'h0)
    else $error("reserved correctable bit flagged");
  AST_UNC_RSVD: assert property ((unc_report & ~aer_pkg::AER_UNC_IMPL) == 32'h0)
    else $error("reserved uncorrectable bit reported");
  AST_FATAL_CAUSE: assert property (report_fatal |-> unc_report != 32'h0)
    else $error("fatal message without report");
  AST_NONFATAL_CAUSE: assert property (report_nonfatal |-> unc_report != 32'h0)
    else $error("non-fatal message without report");
  AST_REPORT_PULSE: assert property (unc_report != 32'h0 |=> unc_report == 32'h0)
    else $error("report longer than one cycle");
  AST_ADV_PULSE: assert property (cor_detected[13] |=> !cor_detected[13])
    else $error("advisory flag longer than one cycle");
endmodule // aer_bank_monitor
bind aer_bank aer_bank_monitor aer_bank_monitor_i (.aclk(aclk), .aresetn(aresetn),
  .cor_event(cor_event), .unc_report(unc_report), .report_fatal(report_fatal),
  .report_nonfatal(report_nonfatal), .cor_detected(cor_detected));

// *** verif/aer_rc_model.sv ***
// Root complex stand-in that counts error messages.
// Assumes report pulses last one aclk cycle.
`timescale 1ns/10ps
module aer_rc_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] unc_report,
  input wire logic report_fatal,
  input wire logic report_nonfatal,
  output logic [7:0] n_msg,
  output logic [7:0] n_nonfatal,
  output logic [7:0] n_fatal,
  output logic [31:0] last_report
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_msg <= 8'h00;
      n_fatal <= 8'h00;
      n_nonfatal <= 8'h00;
      last_report <= 32'h0;
    end else if (unc_report != 32'h0) begin
      n_msg <= n_msg + 8'h01;
      n_fatal <= n_fatal + {7'h0, report_fatal};
      n_nonfatal <= n_nonfatal + {7'h0, report_nonfatal};
      last_report <= unc_report;
    end
  end
endmodule // aer_rc_model

// *** verif/aer_bank_test.sv ***
// Self-checking bench of the error bank.
// Assumes the checker and root complex model are compiled first.
`timescale 1ns/10ps
module aer_bank_test;
  localparam logic [11:0] MSK = aer_pkg::AER_UNC_MASK_OFFSET;
  localparam logic [11:0] SEV = aer_pkg::AER_UNC_SEV_OFFSET;
  localparam logic [11:0] COR = aer_pkg::AER_COR_STATUS_OFFSET;
  logic aclk = 1'b0, aresetn = 1'b0, sticky_resetn = 1'b0;
  logic [11:0] aw = 12'h0, ar = 12'h0;
  logic [31:0] wd = 32'h0, unc_event = 32'h0, cor_event = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic awr, wrr, bv, arr, rv, irq, fat, nfat;
  logic [1:0] br, rr, resp;
  logic [31:0] rdat, rd_data, unc_report, cor_det, last_report;
  logic [7:0] n_msg, n_fatal, n_nonfatal, m0, m1;
  int n_mismatch = 0, checks_done = 0;
  initial forever #4 aclk = ~aclk;
  aer_bank aer_bank_i (.aclk(aclk), .aresetn(aresetn), .sticky_resetn(sticky_resetn),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .unc_event(unc_event), .cor_event(cor_event),
    .unc_report(unc_report), .report_fatal(fat), .report_nonfatal(nfat),
    .cor_detected(cor_det), .irq(irq));
  aer_rc_model aer_rc_model_i (.aclk(aclk), .aresetn(aresetn), .unc_report(unc_report),
    .report_fatal(fat), .report_nonfatal(nfat), .n_msg(n_msg), .n_nonfatal(n_nonfatal),
    .n_fatal(n_fatal), .last_report(last_report));
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int k;
    aw <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      if (bv) break;
    end
    bre <= 1'b0;
    resp = br;
    if (k == 40) begin n_mismatch++; tally_and_finish(); end
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    int k;
    ar <= a; arv <= 1'b1; rre <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rre <= 1'b0;
    rd_data = rdat;
    resp = rr;
    if (k == 40) begin n_mismatch++; tally_and_finish(); end
    @(posedge aclk);
  endtask
  // Events held three cycles, then low long enough for the synchroniser
  task automatic pulse(input logic [31:0] u, input logic [31:0] c);
    unc_event <= u; cor_event <= c;
    repeat (3) @(posedge aclk);
    unc_event <= 32'h0; cor_event <= 32'h0;
    repeat (8) @(posedge aclk);
  endtask
  task automatic t_reset_values;
    rd(MSK); chk(rd_data, 32'h0);
    rd(SEV); chk(rd_data & 32'h00050000, 32'h00040000);
    chk(rd_data, aer_pkg::AER_UNC_SEV_RESET);
    chk(rd_data & ~aer_pkg::AER_UNC_IMPL, 32'h0);
    rd(COR); chk(rd_data, 32'h0);
    rd(12'h300); chk({30'h0, resp}, {30'h0, aer_pkg::AER_RESP_SLVERR});
    wr(MSK, 32'hFFFFFFFF); rd(MSK); chk(rd_data, aer_pkg::AER_UNC_IMPL);
  endtask
  task automatic t_mask_bits;
    for (int b = 0; b < 22; b++) if (aer_pkg::AER_UNC_IMPL[b]) begin
      wr(MSK, 32'h0); wr(SEV, 32'h1 << b); m0 = n_fatal;
      pulse(32'h1 << b, 32'h0);
      chk(last_report, 32'h1 << b);
      chk({24'h0, n_fatal - m0}, 32'h1);
      wr(MSK, 32'h1 << b); m0 = n_msg;
      pulse(32'h1 << b, 32'h0);
      chk({24'h0, n_msg - m0}, 32'h0);
    end
    wr(MSK, 32'h0); wr(SEV, 32'h0); m0 = n_fatal; m1 = n_nonfatal;
    pulse(32'h00010000, 32'h0);
    chk({24'h0, n_fatal - m0}, 32'h0);
    chk({24'h0, n_nonfatal - m1}, 32'h1);
  endtask
  task automatic t_cor_status;
    wr(aer_pkg::AER_IRQ_MASK_OFFSET, 32'h4);
    for (int b = 0; b < 14; b++) if (aer_pkg::AER_COR_IMPL[b]) begin
      pulse(32'h0, 32'h1 << b);
      wr(COR, ~(32'h1 << b)); rd(COR); chk(rd_data, 32'h1 << b);
      chk({31'h0, irq}, 32'h1);
      wr(COR, 32'h1 << b); rd(COR); chk(rd_data, 32'h0);
      wr(aer_pkg::AER_IRQ_STATUS_OFFSET, 32'h4); rd(COR); chk({31'h0, irq}, 32'h0);
    end
  endtask
  // Ordinary reset alone must leave the sticky status in place
  task automatic t_sticky;
    pulse(32'h0, 32'h80);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(COR); chk(rd_data, 32'h80);
    rd(SEV); chk(rd_data, 32'h0);
    // Only the sticky reset brings back the power-up values
    sticky_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    sticky_resetn <= 1'b1;
    rd(COR); chk(rd_data, 32'h0);
    rd(SEV); chk(rd_data, aer_pkg::AER_UNC_SEV_RESET);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    sticky_resetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_values();
    t_mask_bits();
    t_cor_status();
    t_sticky();
    tally_and_finish();
  end
endmodule // aer_bank_test
